// >>> hw/uhp_pkg.sv
// constants and carrier types for the upconverter host port
package uhp_pkg;

  // ----------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;                 // host data bus width
  localparam int ADDR_W = 7;                  // host address bus width
  localparam int NUM_CH = 4;                  // channel count
  localparam int CH_REGS = 24;                // channel words 0x00..0x17
  localparam int IDX_W = 5;                   // channel word index width
  localparam int SYNC_CLOCKS = 4;             // master to slave sync interval, clocks
  localparam int PIPE_LEN = SYNC_CLOCKS - 1;  // pipe stages before the action cycle

  // ----------------------------------------------------------------
  // direct offsets
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] OFS_SAMPLE1 = 5'h01;      // sample control word 1
  localparam logic [IDX_W-1:0] OFS_SAMPLE0 = 5'h00;      // sample control word 0
  localparam logic [IDX_W-1:0] OFS_MAIN_CTRL = 5'h0C;    // main channel control
  localparam logic [IDX_W-1:0] OFS_IMMED_ACT = 5'h0F;    // immediate action control
  localparam logic [IDX_W-1:0] OFS_SERIAL_CTRL = 5'h11;  // serial control
  localparam logic [IDX_W-1:0] OFS_RAM_DATA = 5'h14;     // indirect_ram_data
  localparam logic [IDX_W-1:0] OFS_RAM_ADDR = 5'h15;     // indirect_ram_address
  localparam logic [ADDR_W-1:0] OFS_TOP_BASE = 7'h78;    // start of top control region
  localparam logic [ADDR_W-1:0] OFS_DEV_CTRL = 7'h78;    // device control
  localparam logic [ADDR_W-1:0] OFS_CHAN_PTR = 7'h7A;    // channel pointer
  localparam logic [ADDR_W-1:0] OFS_TOP_CTRL = 7'h7F;    // top control

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MAIN_IMMED_BIT = 15;         // immediate update
  localparam int MAIN_GAIN_HOLD_BIT = 14;     // gain profile hold
  localparam int MAIN_UP_HOLD_BIT = 12;       // processor hold for coefficients
  localparam int IMMED_SOFT_RST_BIT = 1;      // channel soft reset
  localparam int SERIAL_SER_BIT = 15;         // serial sample input when set
  localparam int DEV_BCAST_BIT = 0;           // broadcast to all channels
  localparam int TOP_HARD_RST_BIT = 1;        // device hard reset
  localparam int IND_READ_BIT = 15;           // indirect access type
  localparam int IND_PAGE_LO = 8;             // indirect page field low bit
  localparam logic [1:0] PAGE_GAIN = 2'h0;    // gain profile page

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] MASTER_RST = 16'h0000;
  localparam logic [DATA_W-1:0] SLAVE_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DEV_CTRL_RST = 16'h0000;
  localparam logic [1:0] CHAN_PTR_RST = 2'h0;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ce_n;                   // chip enable, low active
    logic rd_n;                   // read strobe, or read/write when style high
    logic wr_n;                   // write strobe, or data strobe when style high
    logic strobe_style_select;    // strobe style
    logic [ADDR_W-1:0] addr;      // address bus
    logic [DATA_W-1:0] data;      // data bus input side
  } uhp_host_t;

  typedef struct packed {
    logic vld;                    // pending write
    logic [NUM_CH-1:0] chans;     // channels written
    logic [IDX_W-1:0] idx;        // word written
  } uhp_sync_t;

  typedef struct packed {
    logic [NUM_CH-1:0] wr;        // write pulse per channel
    logic [NUM_CH-1:0] rd;        // read pulse per channel
    logic [1:0] page;             // ram page
    logic [7:0] word;             // word within page
    logic [DATA_W-1:0] wdata;     // write data
  } uhp_ram_req_t;

endpackage : uhp_pkg

// >>> hw/uhp_host_port.sv
// parallel host port of a four channel upconverter
`timescale 1ns/1ps

module uhp_host_port
(
  input wire logic clock_i,                            // device clock, 20 MHz
  input wire logic sys_rst_i,                          // hard reset, sync, high
  input wire uhp_pkg::uhp_host_t host_i,               // host pins, sampled
  output logic [uhp_pkg::DATA_W-1:0] data_o,           // data bus output value
  output logic data_oe_o,                              // data bus output enable
  input wire logic [uhp_pkg::NUM_CH-1:0] update_i,     // per channel update event
  output uhp_pkg::uhp_ram_req_t ram_req_o,             // indirect ram request
  input wire logic [uhp_pkg::DATA_W-1:0] ram_rdata_i,  // ram read data, next cycle
  output logic [uhp_pkg::NUM_CH-1:0] gain_hold_o,      // host owns gain ram
  output logic [uhp_pkg::NUM_CH-1:0] coef_hold_o,      // host owns coefficient rams
  output logic [uhp_pkg::NUM_CH-1:0] sample_push_o,    // sample entered fifo head
  output logic [uhp_pkg::NUM_CH-1:0] soft_reset_o,     // channel soft reset pulse
  output logic hard_reset_o                            // device hard reset level
);
  import uhp_pkg::*;
  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // one-hot channel mask from a pointer
  function automatic logic [NUM_CH-1:0] ch_onehot(input logic [1:0] ptr);
    logic [NUM_CH-1:0] m;
    m = '0;
    m[ptr] = 1'b1;
    return m;
  endfunction : ch_onehot
  // lowest channel in a mask
  function automatic logic [1:0] first_ch(input logic [NUM_CH-1:0] m);
    logic [1:0] c;
    c = 2'h0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (m[i]) begin
        c = 2'(i);
      end
    end
    return c;
  endfunction : first_ch
  // words copied by an update: not samples, indirect pair or actions
  function automatic logic is_config(input logic [IDX_W-1:0] idx);
    return (idx != OFS_SAMPLE0) && (idx != OFS_SAMPLE1) && (idx != OFS_RAM_DATA) &&
           (idx != OFS_RAM_ADDR) && (idx != OFS_IMMED_ACT);
  endfunction : is_config

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] master [NUM_CH][CH_REGS];   // host written masters
  logic [DATA_W-1:0] slave [NUM_CH][CH_REGS];    // device clocked slaves
  logic [DATA_W-1:0] dev_ctrl;                   // device control word
  logic [1:0] chan_ptr;                          // channel reached by single writes
  logic [DATA_W-1:0] ram_back;                   // last indirect read result
  logic ram_rd_q;                                // indirect read in flight
  logic hard_req, hard_rst;                      // top control request, combined reset
  logic wr_act, rd_act;                          // write and read strobes active
  logic wr_act_q;                                // write strobe last cycle
  logic wr_event;                                // end of a write strobe
  logic [ADDR_W-1:0] wr_addr_q;                  // address caught during strobe
  logic [DATA_W-1:0] wr_data_q;                  // data caught during strobe
  logic ch_wr;                                   // write hits channel space
  logic [IDX_W-1:0] wr_idx;                      // channel word written
  logic [NUM_CH-1:0] wr_chans;                   // channels a write reaches
  uhp_sync_t pipe [PIPE_LEN];                    // four clock sync pipe
  uhp_sync_t act;                                // pipe entry acted on now
  logic [DATA_W-1:0] next_rdata;                 // read mux result

  assign hard_rst = sys_rst_i | hard_req;
  assign hard_reset_o = hard_rst;
  assign act = pipe[PIPE_LEN-1];

  // ----------------------------------------------------------------
  // strobe decode
  // ----------------------------------------------------------------
  // strobe style and chip enable gating
  always_comb begin
    if (host_i.ce_n) begin
      wr_act = 1'b0;
      rd_act = 1'b0;
    end else if (host_i.strobe_style_select) begin
      wr_act = ~host_i.wr_n & ~host_i.rd_n;
      rd_act = ~host_i.wr_n & host_i.rd_n;
    end else begin
      wr_act = ~host_i.wr_n;
      rd_act = ~host_i.rd_n;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      wr_act_q <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
    end else begin
      wr_act_q <= wr_act;
      if (wr_act) begin
        wr_addr_q <= host_i.addr;
        wr_data_q <= host_i.data;
      end
    end
  end

  // write taken on the closing strobe edge
  assign wr_event = wr_act_q & ~wr_act;
  // channel words below 0x18, top words from 0x78
  assign ch_wr = wr_event && (wr_addr_q < ADDR_W'(CH_REGS));
  assign wr_idx = wr_addr_q[IDX_W-1:0];
  assign wr_chans = dev_ctrl[DEV_BCAST_BIT] ? {NUM_CH{1'b1}} : ch_onehot(chan_ptr);

  // ----------------------------------------------------------------
  // top control region
  // ----------------------------------------------------------------
  // device control and channel pointer
  always_ff @(posedge clock_i) begin
    if (hard_rst) begin
      dev_ctrl <= DEV_CTRL_RST;
      chan_ptr <= CHAN_PTR_RST;
    end else if (wr_event) begin
      if (wr_addr_q == OFS_DEV_CTRL) begin
        dev_ctrl <= wr_data_q;
      end
      if (wr_addr_q == OFS_CHAN_PTR) begin
        chan_ptr <= wr_data_q[1:0];
      end
    end
  end

  // hard reset pulse from top control, one clock long
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      hard_req <= 1'b0;
    end else begin
      hard_req <= wr_event && (wr_addr_q == OFS_TOP_CTRL) && wr_data_q[TOP_HARD_RST_BIT];
    end
  end

  // ----------------------------------------------------------------
  // master registers
  // ----------------------------------------------------------------
  // master write, cleared by hard reset alone
  always_ff @(posedge clock_i) begin
    for (int c = 0; c < NUM_CH; c++) begin
      for (int r = 0; r < CH_REGS; r++) begin
        if (hard_rst) begin
          master[c][r] <= MASTER_RST;
        end else if (ch_wr && wr_chans[c] && (wr_idx == IDX_W'(r))) begin
          master[c][r] <= wr_data_q;
        end
      end
    end
  end

  // soft reset pulse from immediate action word
  always_ff @(posedge clock_i) begin
    if (hard_rst) begin
      soft_reset_o <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        soft_reset_o[c] <= ch_wr && wr_chans[c] && (wr_idx == OFS_IMMED_ACT) &&
                           wr_data_q[IMMED_SOFT_RST_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // synchronisation pipe
  // ----------------------------------------------------------------
  // four clock interval after each channel write
  always_ff @(posedge clock_i) begin
    if (hard_rst) begin
      for (int s = 0; s < PIPE_LEN; s++) begin
        pipe[s] <= '0;
      end
    end else begin
      pipe[0] <= '{vld: ch_wr, chans: wr_chans, idx: wr_idx};
      for (int s = 1; s < PIPE_LEN; s++) begin
        pipe[s] <= pipe[s-1];
      end
    end
  end

  // ----------------------------------------------------------------
  // slave registers
  // ----------------------------------------------------------------
  // slaves cleared by hard or soft reset
  always_ff @(posedge clock_i) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (hard_rst || soft_reset_o[c]) begin
        for (int r = 0; r < CH_REGS; r++) begin
          slave[c][r] <= SLAVE_RST;
        end
      // event update copies every configuration word
      end else if (update_i[c] && !master[c][OFS_MAIN_CTRL][MAIN_IMMED_BIT]) begin
        for (int r = 0; r < CH_REGS; r++) begin
          if (is_config(IDX_W'(r))) begin
            slave[c][r] <= master[c][r];
          end
        end
      end else if (act.vld && act.chans[c]) begin
        // word 0 pushes both sample masters
        if ((act.idx == OFS_SAMPLE0) && !slave[c][OFS_SERIAL_CTRL][SERIAL_SER_BIT]) begin
          slave[c][OFS_SAMPLE0] <= master[c][OFS_SAMPLE0];
          slave[c][OFS_SAMPLE1] <= master[c][OFS_SAMPLE1];
        end else if (is_config(act.idx) && master[c][OFS_MAIN_CTRL][MAIN_IMMED_BIT]) begin
          slave[c][act.idx] <= master[c][act.idx];
        end
      end
    end
  end

  // sample push marks the fifo head loaded
  always_ff @(posedge clock_i) begin
    if (hard_rst) begin
      sample_push_o <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        sample_push_o[c] <= act.vld && act.chans[c] && (act.idx == OFS_SAMPLE0) &&
                            !slave[c][OFS_SERIAL_CTRL][SERIAL_SER_BIT] && !soft_reset_o[c];
      end
    end
  end

  // ram ownership from the live control words
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      gain_hold_o[c] = slave[c][OFS_MAIN_CTRL][MAIN_GAIN_HOLD_BIT];
      coef_hold_o[c] = slave[c][OFS_MAIN_CTRL][MAIN_UP_HOLD_BIT];
    end
  end

  // ----------------------------------------------------------------
  // indirect ram access
  // ----------------------------------------------------------------
  // ram move on the action cycle of an address write
  always_ff @(posedge clock_i) begin
    logic [DATA_W-1:0] ia;
    logic own;
    if (hard_rst) begin
      ram_req_o <= '0;
    end else begin
      ram_req_o.wr <= '0;
      ram_req_o.rd <= '0;
      if (act.vld && (act.idx == OFS_RAM_ADDR)) begin
        ia = master[first_ch(act.chans)][OFS_RAM_ADDR];
        // page from bits 9:8, word from 7:0
        ram_req_o.page <= ia[IND_PAGE_LO+1:IND_PAGE_LO];
        ram_req_o.word <= ia[7:0];
        ram_req_o.wdata <= master[first_ch(act.chans)][OFS_RAM_DATA];
        for (int c = 0; c < NUM_CH; c++) begin
          // access only while the host holds that ram
          own = (ia[IND_PAGE_LO+1:IND_PAGE_LO] == PAGE_GAIN) ? gain_hold_o[c] : coef_hold_o[c];
          // bit 15 picks read or write
          ram_req_o.rd[c] <= act.chans[c] && own && ia[IND_READ_BIT];
          ram_req_o.wr[c] <= act.chans[c] && own && !ia[IND_READ_BIT];
        end
      end
    end
  end

  // read result held for the data register
  always_ff @(posedge clock_i) begin
    if (hard_rst) begin
      ram_rd_q <= 1'b0;
      ram_back <= '0;
    end else begin
      ram_rd_q <= |ram_req_o.rd;
      if (ram_rd_q) begin
        ram_back <= ram_rdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // register selected by the live address
  always_comb begin
    next_rdata = '0;
    if (host_i.addr == OFS_DEV_CTRL) begin
      next_rdata = dev_ctrl;
    end else if (host_i.addr == OFS_CHAN_PTR) begin
      next_rdata = {14'h0000, chan_ptr};
    end else if (host_i.addr < ADDR_W'(CH_REGS)) begin
      if (host_i.addr[IDX_W-1:0] == OFS_RAM_DATA) begin
        next_rdata = ram_back;
      end else if (host_i.addr[IDX_W-1:0] == OFS_RAM_ADDR) begin
        next_rdata = master[chan_ptr][OFS_RAM_ADDR];
      end else if (host_i.addr[IDX_W-1:0] != OFS_IMMED_ACT) begin
        next_rdata = slave[chan_ptr][host_i.addr[IDX_W-1:0]];
      end
    end
  end

  // drive the bus while the read strobe is held
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      data_o <= '0;
      data_oe_o <= 1'b0;
    end else begin
      data_oe_o <= rd_act;
      data_o <= next_rdata;
    end
  end
endmodule : uhp_host_port

// >>> testbench/uhp_ram_model.sv
// behavioural model of the rams behind the indirect port
`timescale 1ns/1ps

module uhp_ram_model
  import uhp_pkg::*;
(
  input wire logic clock_i,                       // device clock
  input wire uhp_pkg::uhp_ram_req_t ram_req_i,    // request from the port
  output logic [uhp_pkg::DATA_W-1:0] ram_rdata_o  // read word, cycle after request
);
  logic [DATA_W-1:0] mem [0:1023];  // four pages of 256 words

  initial ram_rdata_o = 16'hA5A5;

  // write pulse stores at page and word
  always @(posedge clock_i) begin
    if (|ram_req_i.wr) begin
      mem[{ram_req_i.page, ram_req_i.word}] <= ram_req_i.wdata;
    end
  end

  // read answered next cycle, scrambled otherwise
  always @(posedge clock_i) begin
    if (|ram_req_i.rd) begin
      ram_rdata_o <= mem[{ram_req_i.page, ram_req_i.word}];
    end else begin
      ram_rdata_o <= ~ram_rdata_o;  // no stale word survives
    end
  end
endmodule : uhp_ram_model

// >>> testbench/uhp_host_port_sva.sv
// assertion checker for the upconverter host port
`timescale 1ns/1ps

module uhp_host_port_sva
  import uhp_pkg::*;
(
  input wire logic clock_i,                            // device clock
  input wire logic sys_rst_i,                          // hard reset
  input wire uhp_pkg::uhp_host_t host_i,               // host pins
  input wire logic data_oe_o,                          // bus drive enable
  input wire uhp_pkg::uhp_ram_req_t ram_req_o,         // ram request
  input wire logic [uhp_pkg::NUM_CH-1:0] sample_push_o, // sample push pulses
  input wire logic [uhp_pkg::NUM_CH-1:0] soft_reset_o,  // soft reset pulses
  input wire logic hard_reset_o                        // hard reset level
);
  // ----
  // strobe decode and write event
  // ----
  logic wr_act;              // write condition
  logic rd_act;              // read condition
  logic wr_q;                // write condition last edge
  logic ev;                  // write event
  logic [ADDR_W-1:0] a_q;    // address last edge
  logic [DATA_W-1:0] d_q;    // data last edge

  assign wr_act = !host_i.ce_n && !host_i.wr_n
                  && (!host_i.strobe_style_select || !host_i.rd_n);
  assign rd_act = !host_i.ce_n && (host_i.strobe_style_select
                  ? (!host_i.wr_n && host_i.rd_n) : !host_i.rd_n);
  assign ev = wr_q && !wr_act;

  // capture of the last strobe sample
  always_ff @(posedge clock_i) begin
    wr_q <= wr_act;
    a_q <= host_i.addr;
    d_q <= host_i.data;
  end

  // ----
  // properties
  // ----
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_soft_cmd;
    ev && a_q == 7'h0F && d_q[IMMED_SOFT_RST_BIT];
  endsequence
  sequence s_hard_cmd;
    ev && a_q == OFS_TOP_CTRL && d_q[TOP_HARD_RST_BIT];
  endsequence

  property p_oe_on;
    rd_act |=> data_oe_o;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("bus not driven after read");
  property p_no_ce;
    host_i.ce_n |=> !data_oe_o;
  endproperty
  a_no_ce: assert property (p_no_ce) else $error("bus driven without select");
  property p_ram_wr;
    |ram_req_o.wr |-> $past(ev && a_q == 7'h15 && !d_q[IND_READ_BIT], 4)
      && {ram_req_o.page, ram_req_o.word} == $past(d_q[9:0], 4);
  endproperty
  a_ram_wr: assert property (p_ram_wr) else $error("ram write out of place");
  property p_ram_rd;
    |ram_req_o.rd |-> $past(ev && a_q == 7'h15 && d_q[IND_READ_BIT], 4)
      && ram_req_o.page == $past(d_q[9:8], 4);
  endproperty
  a_ram_rd: assert property (p_ram_rd) else $error("ram read out of place");
  property p_push;
    |sample_push_o |-> $past(ev && a_q == 7'h00, 4);
  endproperty
  a_push: assert property (p_push) else $error("push without word 0 write");
  property p_soft;
    s_soft_cmd |-> ##[1:2] (|soft_reset_o);
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset not issued");
  property p_hard_cmd;
    s_hard_cmd |-> ##[1:2] hard_reset_o;
  endproperty
  a_hard_cmd: assert property (p_hard_cmd) else $error("hard reset not issued");
  property p_hard_pin;
    disable iff (1'b0) sys_rst_i |-> hard_reset_o;
  endproperty
  a_hard_pin: assert property (p_hard_pin) else $error("reset pin not passed on");
endmodule : uhp_host_port_sva

// >>> testbench/uhp_host_port_bench.sv
// self-checking bench for the upconverter host port
`timescale 1ns/1ps

module uhp_host_port_bench;
  import uhp_pkg::*;
  logic clock_i = 1'b0;                   // device clock
  logic sys_rst_i = 1'b1;                 // hard reset
  uhp_host_t host_i;                      // host pins
  logic [NUM_CH-1:0] update_i = 4'h0;     // update events
  logic [DATA_W-1:0] data_o;              // read data
  logic [DATA_W-1:0] ram_rdata_i;         // ram answer
  logic data_oe_o;                        // bus drive
  logic hard_reset_o;                     // hard reset level
  uhp_ram_req_t ram_req_o;                // ram request
  logic [NUM_CH-1:0] gain_hold_o, coef_hold_o, sample_push_o, soft_reset_o;
  int bad_count = 0;                      // mismatches
  int comparisons = 0;                    // checks made
  int n_push = 0, n_soft = 0, n_hard = 0, n_ramw = 0, n_ramr = 0;  // pulse counts

  always #25 clock_i = ~clock_i;

  uhp_host_port uhp_host_port_inst (.clock_i, .sys_rst_i, .host_i, .data_o, .data_oe_o,
    .update_i, .ram_req_o, .ram_rdata_i, .gain_hold_o, .coef_hold_o, .sample_push_o,
    .soft_reset_o, .hard_reset_o);
  uhp_ram_model uhp_ram_model_inst (.clock_i, .ram_req_i(ram_req_o), .ram_rdata_o(ram_rdata_i));

  // ----
  // tasks
  // ----
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    if (bad_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  // one strobe cycle, then spacing of six clocks
  task automatic wr(input logic [6:0] a, input logic [15:0] d, input bit ce = 1'b0);
    @(posedge clock_i) #1;
    host_i.ce_n = ce;
    host_i.wr_n = 1'b0;
    host_i.rd_n = !host_i.strobe_style_select;
    host_i.addr = a;
    host_i.data = d;
    @(posedge clock_i) #1;
    host_i.ce_n = 1'b1;
    host_i.wr_n = 1'b1;
    host_i.rd_n = 1'b1;
    // same register accesses kept at least four clocks apart
    repeat (6) @(posedge clock_i);
    #1;
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [15:0] e, input bit ce = 1'b0);
    @(posedge clock_i) #1;
    host_i.ce_n = ce;
    host_i.rd_n = host_i.strobe_style_select;
    host_i.wr_n = !host_i.strobe_style_select;
    host_i.addr = a;
    @(posedge clock_i) #1;
    check("bus drive", {15'h0000, data_oe_o}, {15'h0000, !ce});
    if (!ce) check("read data", data_o, e);
    host_i.ce_n = 1'b1;
    host_i.rd_n = 1'b1;
    host_i.wr_n = 1'b1;
  endtask : rd

  task automatic upd(input logic [3:0] m);
    @(posedge clock_i) #1;
    update_i = m;
    @(posedge clock_i) #1;
    update_i = 4'h0;
  endtask : upd

  // pulse counters outside reset
  always @(posedge clock_i) begin
    if (!sys_rst_i) begin
      n_push += int'(|sample_push_o);
      n_soft += int'(|soft_reset_o);
      n_hard += int'(hard_reset_o);
      n_ramw += int'(|ram_req_o.wr);
      n_ramr += int'(|ram_req_o.rd);
    end
  end

  // hang guard
  initial begin
    repeat (40000) @(posedge clock_i);
    bad_count++;
    finish_test();
  end

  // ----
  // main sequence
  // ----
  initial begin
    host_i = {1'b1, 1'b1, 1'b1, 1'b0, 7'h00, 16'h0000};
    repeat (4) @(posedge clock_i);
    #1 sys_rst_i = 1'b0;
    rd(7'h0C, 16'h0000);
    rd(7'h20, 16'h0000);
    wr(7'h0C, 16'h9000);
    rd(7'h0C, 16'h9000);
    check("coef hold", 16'(coef_hold_o), 16'h0001);
    wr(7'h0C, 16'hD000);
    check("gain hold", 16'(gain_hold_o), 16'h0001);
    wr(7'h08, 16'h1234);
    rd(7'h08, 16'h1234);
    for (int p = 0; p < 2; p++) begin
      wr(7'h14, 16'h5A50 + 16'(p));
      wr(7'h15, {6'h00, 2'(p), 8'h03});
      wr(7'h15, {6'h20, 2'(p), 8'h03});
      rd(7'h14, 16'h5A50 + 16'(p));
    end
    check("ram writes", 16'(n_ramw), 16'h0002);
    check("ram reads", 16'(n_ramr), 16'h0002);
    wr(7'h11, 16'h0000);
    wr(7'h01, 16'h1111);
    check("early push", 16'(n_push), 16'h0000);
    wr(7'h00, 16'h2222);
    check("push", 16'(n_push), 16'h0001);
    rd(7'h00, 16'h2222);
    rd(7'h01, 16'h1111);
    wr(7'h0F, 16'h0002);
    check("soft reset", 16'(n_soft), 16'h0001);
    rd(7'h08, 16'h0000);
    wr(7'h15, 16'h0003);
    check("refused ram write", 16'(n_ramw), 16'h0002);
    wr(7'h0C, 16'h4000);
    upd(4'h1);
    rd(7'h08, 16'h1234);
    rd(7'h0C, 16'h4000);
    check("gain hold", 16'(gain_hold_o), 16'h0001);
    wr(7'h08, 16'hFFFF, 1'b1);
    upd(4'h1);
    rd(7'h08, 16'h1234);
    rd(7'h08, 16'h0000, 1'b1);
    host_i.strobe_style_select = 1'b1;
    wr(7'h09, 16'h0BEE);
    upd(4'h1);
    rd(7'h09, 16'h0BEE);
    host_i.strobe_style_select = 1'b0;
    wr(7'h78, 16'h0001);
    wr(7'h08, 16'h7777);
    upd(4'hF);
    wr(7'h78, 16'h0000);
    wr(7'h7A, 16'h0002);
    rd(7'h08, 16'h7777);
    rd(7'h09, 16'h0000);
    wr(7'h7F, 16'h0002);
    check("hard reset", 16'(n_hard), 16'h0001);
    upd(4'hF);
    rd(7'h08, 16'h0000);
    finish_test();
  end
endmodule : uhp_host_port_bench

bind uhp_host_port uhp_host_port_sva uhp_host_port_sva_inst (.clock_i, .sys_rst_i, .host_i,
  .data_oe_o, .ram_req_o, .sample_push_o, .soft_reset_o, .hard_reset_o);
